// >>> bench/gar_alarm_props.sv
// gar_alarm_props.sv: port-level checks for the alarm top
// assumes: bound into gar_alarm_top; config held steady while checked
module gar_alarm_props #(
    parameter NCH = 16,
    parameter RW  = 12
) (
    // clock and reset
    input wire              i_clk,
    input wire              i_rstn,
    // watched inputs
    input wire [NCH*RW-1:0] i_reading,
    input wire [NCH-1:0]    i_ch_enable,
    input wire [NCH-1:0]    i_ch_fault,
    input wire [RW-1:0]     i_first_gas_threshold,
    input wire [RW-1:0]     i_third_gas_threshold,
    input wire [3:0]        i_cfg_energized,
    input wire [3:0]        i_cfg_latching,
    input wire [3:0]        i_cfg_silenceable,
    input wire              i_cfg_onbox_en,
    input wire              i_cfg_ext_en,
    input wire              i_panel_silence,
    input wire              i_panel_reset,
    input wire              i_ext_ack,
    // watched outputs
    input wire              o_strobe,
    input wire [3:0]        o_ext_relay,
    input wire              o_low_level_alarm_lamp,
    input wire              o_mid_level_alarm_lamp,
    input wire              o_fault_lamp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ov1, ov3, flt;
    always_comb begin
        ov1 = 1'b0;
        ov3 = 1'b0;
        for (int g = 0; g < NCH; g++) begin
            ov1 |= i_ch_enable[g] && (i_reading[g*RW+:RW] > i_first_gas_threshold);
            ov3 |= i_ch_enable[g] && (i_reading[g*RW+:RW] > i_third_gas_threshold);
        end
        flt = |(i_ch_fault & i_ch_enable);
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    // long enough that no switch edge is still in the synchroniser
    sequence quiet_s;
        (!i_panel_silence && !i_panel_reset && !i_ext_ack) [*4];
    endsequence
    // one cycle of slack: the first edge after reset may still hold outputs
    sequence held1_s;
        (ov1 && !i_cfg_silenceable[0]) [*3];
    endsequence
    a_lamp_on: assert property (held1_s |=> o_low_level_alarm_lamp)
        else $error("low lamp did not follow reading");
    a_strobe_on: assert property ((ov1 && !i_cfg_silenceable[0] && i_cfg_onbox_en) [*4] |=> o_strobe)
        else $error("strobe did not follow first level");
    a_relay_open: assert property ((held1_s ##1 ov1) ##0 (i_cfg_energized[0] && i_cfg_ext_en) [*1] |=> !o_ext_relay[0])
        else $error("energized contact not opened");
    a_relay_close: assert property ((ov3 && !i_cfg_energized[2] && !i_cfg_silenceable[2] && i_cfg_ext_en) [*4] |=> o_ext_relay[2])
        else $error("de-energized contact not closed");
    a_ext_off: assert property ((!i_cfg_ext_en) [*4] |=> (o_ext_relay == 4'h0))
        else $error("relays driven while disabled");
    a_lamp_clear: assert property ((!ov1 && !i_cfg_latching[0]) [*4] |=> !o_low_level_alarm_lamp)
        else $error("low lamp stuck after clear");
    a_fault_lamp: assert property ((flt && !i_cfg_silenceable[3]) [*3] |=> o_fault_lamp)
        else $error("fault lamp missing");
    a_latch_hold: assert property (quiet_s ##0 (i_cfg_latching[2] && !i_cfg_energized[2] && i_cfg_ext_en && o_ext_relay[2]) |=> o_ext_relay[2])
        else $error("latched relay dropped without reset");
    a_silence_mid: assert property ($rose(i_panel_silence) && i_cfg_silenceable[1] |-> ##[2:8] !o_mid_level_alarm_lamp)
        else $error("silence ignored on mid level");
endmodule // gar_alarm_props

bind gar_alarm_top gar_alarm_props #(.NCH(NCH), .RW(RW)) i_gar_alarm_props (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_reading(i_reading), .i_ch_enable(i_ch_enable),
    .i_ch_fault(i_ch_fault), .i_first_gas_threshold(i_first_gas_threshold),
    .i_third_gas_threshold(i_third_gas_threshold), .i_cfg_energized(i_cfg_energized),
    .i_cfg_latching(i_cfg_latching), .i_cfg_silenceable(i_cfg_silenceable),
    .i_cfg_onbox_en(i_cfg_onbox_en), .i_cfg_ext_en(i_cfg_ext_en),
    .i_panel_silence(i_panel_silence), .i_panel_reset(i_panel_reset), .i_ext_ack(i_ext_ack),
    .o_strobe(o_strobe), .o_ext_relay(o_ext_relay),
    .o_low_level_alarm_lamp(o_low_level_alarm_lamp),
    .o_mid_level_alarm_lamp(o_mid_level_alarm_lamp), .o_fault_lamp(o_fault_lamp)
);

// >>> bench/gar_sensor_model.sv
// gar_sensor_model.sv: channel readings, faults and operator switch pins
// assumes: tasks are called by the bench; pins change at i_clk rise
module gar_sensor_model #(
    parameter NCH = 16,
    parameter RW  = 12
) (
    input  wire               i_clk,
    output logic [NCH*RW-1:0] o_reading,
    output logic [NCH-1:0]    o_ch_fault,
    output logic [4:0]        o_sw
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_reading = '0;
        o_ch_fault = '0;
        o_sw = '0;
    end
    task automatic set_rd(input int ch, input logic [RW-1:0] v);
        @(posedge i_clk);
        o_reading[ch*RW+:RW] <= v;
    endtask
    task automatic set_flt(input int ch, input logic f);
        @(posedge i_clk);
        o_ch_fault[ch] <= f;
    endtask
    // switch order: silence, reset, ext ack, up, down; held 2 cycles for the edge detect
    task automatic press(input int k);
        @(posedge i_clk);
        o_sw[k] <= 1'b1;
        repeat (2) @(posedge i_clk);
        o_sw[k] <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
    endtask
endmodule // gar_sensor_model

// >>> bench/test_gas_alarm_relay_logic.sv
// test_gas_alarm_relay_logic.sv: directed bench for the alarm top
// assumes: shortened timers; model owns readings, faults and switches
module test_gas_alarm_relay_logic;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NCH = 12;
    localparam int RW  = 12;
    logic              i_clk, i_rstn, onbox, ext;
    logic [RW-1:0]     thr1, thr2, thr3;
    logic [3:0]        cfg_en, cfg_lat, cfg_sil;
    wire  [NCH*RW-1:0] rd;
    wire  [NCH-1:0]    flt;
    wire  [4:0]        sw;
    wire               strobe, horn, manual;
    wire  [3:0]        relay, lamps;
    wire  [7:0]        page;
    wire  [NCH*4-1:0]  stat;
    int                err_count, comparisons, n;
    gar_sensor_model #(.NCH(NCH), .RW(RW)) i_gar_sensor_model (
        .i_clk(i_clk), .o_reading(rd), .o_ch_fault(flt), .o_sw(sw));
    gar_alarm_top #(.NCH(NCH), .RW(RW), .PAGE_TMO_MS(3), .MS_DIV(4), .CYC_MS(3)) i_gar_alarm_top (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_reading(rd), .i_ch_enable({NCH{1'b1}}),
        .i_ch_fault(flt), .i_first_gas_threshold(thr1), .i_second_gas_threshold(thr2),
        .i_third_gas_threshold(thr3), .i_cfg_energized(cfg_en), .i_cfg_latching(cfg_lat),
        .i_cfg_silenceable(cfg_sil), .i_cfg_onbox_en(onbox), .i_cfg_ext_en(ext),
        .i_panel_silence(sw[0]), .i_panel_reset(sw[1]), .i_ext_ack(sw[2]),
        .i_arrow_up(sw[3]), .i_arrow_down(sw[4]), .o_strobe(strobe), .o_horn(horn),
        .o_ext_relay(relay), .o_low_level_alarm_lamp(lamps[0]),
        .o_mid_level_alarm_lamp(lamps[1]), .o_high_level_alarm_lamp(lamps[2]),
        .o_fault_lamp(lamps[3]), .o_page(page), .o_ch_status(stat), .o_manual_paging(manual));
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // level 1 energized; level 2 silenceable; level 3 latching; all else plain
    initial begin
        {i_rstn, onbox, ext, thr1, thr2, thr3} = {3'b011, 12'h064, 12'h0c8, 12'h12c};
        {cfg_en, cfg_lat, cfg_sil} = {4'h1, 4'h4, 4'h2};
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'b1;
        cyc(5);
        chk("idle relay", 8'h01, {4'h0, relay});
        i_gar_sensor_model.set_rd(9, 12'h0fa);
        cyc(5);
        chk("lamps", 8'h03, {4'h0, lamps});
        chk("on-box", 8'h03, {6'h0, horn, strobe});
        chk("relay", 8'h02, {4'h0, relay});
        chk("page", 8'h01, page);
        chk("status", 8'h03, {4'h0, stat[9*4+:4]});
        i_gar_sensor_model.press(0);
        chk("silenced lamps", 8'h01, {4'h0, lamps});
        chk("silenced relay", 8'h00, {4'h0, relay});
        for (int r = 1; r < 3; r++) begin
            i_gar_sensor_model.set_rd(9, 12'h136);
            cyc(5);
            // second pass: the mid level re-rises, so its earlier silence no longer applies
            chk("third relay", (r == 1) ? 8'h04 : 8'h06, {4'h0, relay});
            i_gar_sensor_model.set_rd(9, 12'h000);
            cyc(5);
            chk("cleared lamps", 8'h00, {6'h0, lamps[1:0]});
            chk("latched relay", 8'h05, {4'h0, relay});
            i_gar_sensor_model.press(r);
            chk("unlatched relay", 8'h01, {4'h0, relay});
        end
        i_gar_sensor_model.set_rd(9, 12'h0fa);
        cyc(5);
        chk("retrigger lamps", 8'h03, {4'h0, lamps});
        i_gar_sensor_model.set_rd(9, 12'h000);
        i_gar_sensor_model.set_flt(3, 1'b1);
        cyc(5);
        chk("fault lamps", 8'h08, {4'h0, lamps});
        chk("fault relay", 8'h08, {4'h0, relay});
        i_gar_sensor_model.set_flt(3, 1'b0);
        i_gar_sensor_model.press(3);
        chk("manual", 8'h01, {7'h0, manual});
        for (n = 0; n < 60 && manual !== 1'b0; n++) cyc(1);
        chk("manual end", 8'h00, {7'h0, manual});
        @(posedge i_clk);
        {onbox, ext} <= 2'b00;
        i_gar_sensor_model.set_rd(9, 12'h0fa);
        cyc(5);
        chk("disabled outputs", 8'h00, {3'h0, strobe, relay});
        chk("disabled lamps", 8'h03, {4'h0, lamps});
        complete_run();
    end
endmodule // test_gas_alarm_relay_logic

// >>> core/gar_alarm_top.v
// gar_alarm_top.v: alarm evaluation, relays, annunciators, lamps, page select
// assumes: readings and thresholds come from logic on i_clk; switches are raw pins
`include "gar_defs.vh"
module gar_alarm_top #(
    parameter NCH      = 16,
    parameter NWIRED   = `GAR_WIRED_MAX,
    parameter RW       = 12,
    parameter PAGE_TMO_MS = `GAR_PAGE_TMO_MS,
    parameter MS_DIV   = `GAR_MS_DIV,
    parameter CYC_MS   = 2000
) (
    // clock and reset
    input  wire                i_clk,
    input  wire                i_rstn,
    // channel readings, flat NCH*RW, and per channel valid and fault
    input  wire [NCH*RW-1:0]   i_reading,
    input  wire [NCH-1:0]      i_ch_enable,
    input  wire [NCH-1:0]      i_ch_fault,
    // thresholds, shared by all channels
    input  wire [RW-1:0]       i_first_gas_threshold,
    input  wire [RW-1:0]       i_second_gas_threshold,
    input  wire [RW-1:0]       i_third_gas_threshold,
    // per level config, bit order first, second, third, fault
    input  wire [3:0]          i_cfg_energized,
    input  wire [3:0]          i_cfg_latching,
    input  wire [3:0]          i_cfg_silenceable,
    input  wire                i_cfg_onbox_en,
    input  wire                i_cfg_ext_en,
    // panel and external switches, raw pins, active high
    input  wire                i_panel_silence,
    input  wire                i_panel_reset,
    input  wire                i_ext_ack,
    input  wire                i_arrow_up,
    input  wire                i_arrow_down,
    // annunciators and lamps
    output reg                 o_strobe,
    output reg                 o_horn,
    output reg  [3:0]          o_ext_relay,
    output wire                o_low_level_alarm_lamp,
    output wire                o_mid_level_alarm_lamp,
    output wire                o_high_level_alarm_lamp,
    output wire                o_fault_lamp,
    // display and per channel status
    output reg  [7:0]          o_page,
    output reg  [NCH*4-1:0]    o_ch_status,
    output reg                 o_manual_paging
);
    localparam NPAGE  = (NCH + `GAR_PER_PAGE - 1) / `GAR_PER_PAGE;
    localparam [7:0] LAST_PAGE = NPAGE - 1;
    localparam [31:0] TMO_CYC = PAGE_TMO_MS; // ms ticks
    localparam ST_AUTO   = 1'b0;
    localparam ST_MANUAL = 1'b1;

    // pin synchronisers with edge detect, three flops each
    reg  [4:0] sw_s1_q;
    reg  [4:0] sw_s2_q;
    reg  [4:0] sw_s3_q;
    wire [4:0] sw_pin;
    wire [4:0] sw_rise;
    assign sw_pin  = {i_arrow_down, i_arrow_up, i_ext_ack, i_panel_reset, i_panel_silence};
    assign sw_rise = sw_s2_q & ~sw_s3_q;
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sw_s1_q <= 5'h00;
            sw_s2_q <= 5'h00;
            sw_s3_q <= 5'h00;
        end else begin
            sw_s1_q <= sw_pin;
            sw_s2_q <= sw_s1_q;
            sw_s3_q <= sw_s2_q;
        end
    end
    wire silence_cmd = sw_rise[0] | sw_rise[2];
    wire reset_cmd   = sw_rise[1] | sw_rise[2];
    wire arrow_up    = sw_rise[3];
    wire arrow_dn    = sw_rise[4];

    // per channel compare; every enabled channel is compared, whatever the wired limit
    reg  [NCH-1:0] ch_l1;
    reg  [NCH-1:0] ch_l2;
    reg  [NCH-1:0] ch_l3;
    reg  [NCH-1:0] ch_flt;
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            wire [RW-1:0] rd = i_reading[g*RW +: RW];
            wire          en = i_ch_enable[g];
            always @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    ch_l1[g]  <= 1'b0;
                    ch_l2[g]  <= 1'b0;
                    ch_l3[g]  <= 1'b0;
                    ch_flt[g] <= 1'b0;
                    o_ch_status[g*4 +: 4] <= 4'h0;
                end else begin
                    ch_l1[g]  <= en & (rd > i_first_gas_threshold);
                    ch_l2[g]  <= en & (rd > i_second_gas_threshold);
                    ch_l3[g]  <= en & (rd > i_third_gas_threshold);
                    ch_flt[g] <= en & i_ch_fault[g];
                    o_ch_status[g*4 +: 4] <= {ch_flt[g], ch_l3[g], ch_l2[g], ch_l1[g]};
                end
            end
        end
    endgenerate
    wire [3:0] cond;
    assign cond = {|ch_flt, |ch_l3, |ch_l2, |ch_l1};

    // one conditioner per level
    wire [3:0] lvl_act;
    wire [3:0] lvl_contact;
    generate
        for (g = 0; g < `GAR_NUM_LVL; g = g + 1) begin : g_lvl
            gar_level_out u_lvl (
                .i_clk         (i_clk),
                .i_rstn        (i_rstn),
                .i_cond        (cond[g]),
                .i_silence     (silence_cmd),
                .i_reset       (reset_cmd),
                .i_energized   (i_cfg_energized[g]),
                .i_latching    (i_cfg_latching[g]),
                .i_silenceable (i_cfg_silenceable[g]),
                .i_fault_any   (cond[`GAR_LVL_FAULT]),
                .o_active      (lvl_act[g]),
                .o_contact     (lvl_contact[g])
            );
        end
    endgenerate

    // lamps show each level's output state
    assign o_low_level_alarm_lamp  = lvl_act[`GAR_LVL_FIRST];
    assign o_mid_level_alarm_lamp  = lvl_act[`GAR_LVL_SECOND];
    assign o_high_level_alarm_lamp = lvl_act[`GAR_LVL_THIRD];
    assign o_fault_lamp            = lvl_act[`GAR_LVL_FAULT];

    // annunciators and external outputs; disabled external ports rest open
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_strobe    <= 1'b0;
            o_horn      <= 1'b0;
            o_ext_relay <= 4'h0;
        end else begin
            o_strobe    <= i_cfg_onbox_en & lvl_act[`GAR_LVL_FIRST];
            o_horn      <= i_cfg_onbox_en & lvl_act[`GAR_LVL_SECOND];
            o_ext_relay <= i_cfg_ext_en ? lvl_contact : 4'h0;
        end
    end

    // first page holding an alarmed or faulted channel
    reg [7:0]  alarm_page;
    reg        alarm_any;
    reg [31:0] page_idx;
    integer    k;
    always @* begin
        alarm_page = 8'h00;
        alarm_any  = 1'b0;
        page_idx   = 32'h0;
        for (k = NCH - 1; k >= 0; k = k - 1) begin
            if (ch_l1[k] | ch_l2[k] | ch_l3[k] | ch_flt[k]) begin
                alarm_any  = 1'b1;
                page_idx   = k / `GAR_PER_PAGE;
                alarm_page = page_idx[7:0];
            end
        end
    end

    // millisecond tick divider
    reg  [31:0] ms_cnt_q;
    wire        ms_tick = (ms_cnt_q == MS_DIV - 1);
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn)
            ms_cnt_q <= 32'h0;
        else
            ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
    end

    // page selection: auto cycle, alarm hold, manual with timeout
    reg         st_q;
    reg  [31:0] tmo_q;
    reg  [31:0] cyc_q;
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q            <= ST_AUTO;
            tmo_q           <= 32'h0;
            cyc_q           <= 32'h0;
            o_page          <= 8'h00;
            o_manual_paging <= 1'b0;
        end else begin
            case (st_q)
                ST_AUTO: begin
                    if (arrow_up | arrow_dn) begin
                        st_q  <= ST_MANUAL;
                        tmo_q <= 32'h0;
                    end else if (alarm_any) begin
                        o_page <= alarm_page;
                        cyc_q  <= 32'h0;
                    end else if (ms_tick) begin
                        // no alarm: slow round robin over pages
                        if (cyc_q >= CYC_MS - 1) begin
                            cyc_q  <= 32'h0;
                            o_page <= (o_page >= LAST_PAGE) ? 8'h00 : o_page + 8'h01;
                        end else begin
                            cyc_q <= cyc_q + 32'h1;
                        end
                    end
                    if (arrow_up)
                        o_page <= (o_page >= LAST_PAGE) ? 8'h00 : o_page + 8'h01;
                    else if (arrow_dn)
                        o_page <= (o_page == 8'h00) ? LAST_PAGE : o_page - 8'h01;
                end
                ST_MANUAL: begin
                    if (arrow_up | arrow_dn) begin
                        tmo_q <= 32'h0;
                        if (arrow_up)
                            o_page <= (o_page >= LAST_PAGE) ? 8'h00 : o_page + 8'h01;
                        else
                            o_page <= (o_page == 8'h00) ? LAST_PAGE : o_page - 8'h01;
                    end else if (ms_tick) begin
                        if (tmo_q >= TMO_CYC - 1) begin
                            st_q  <= ST_AUTO;
                            cyc_q <= 32'h0;
                        end else begin
                            tmo_q <= tmo_q + 32'h1;
                        end
                    end
                end
                default: st_q <= ST_AUTO;
            endcase
            o_manual_paging <= (st_q == ST_MANUAL);
        end
    end
    // wired channels are the low NWIRED indices; the rest are wireless
    wire unused_wired = (NWIRED > `GAR_WIRED_MAX);
endmodule // gar_alarm_top

// >>> core/gar_level_out.v
// gar_level_out.v: one alarm output conditioner (silence, latch, polarity)
// assumes: all inputs are synchronous to i_clk, commands are one-cycle pulses
`include "gar_defs.vh"
module gar_level_out (
    // clock and reset
    input  wire i_clk,
    input  wire i_rstn,
    // condition and commands
    input  wire i_cond,
    input  wire i_silence,
    input  wire i_reset,
    // configuration
    input  wire i_energized,
    input  wire i_latching,
    input  wire i_silenceable,
    input  wire i_fault_any,
    // outputs
    output reg  o_active,
    output reg  o_contact
);
    reg  latch_q;
    reg  sil_q;
    reg  cond_q;
    wire hold_d;
    wire act_d;
    // latched state held after cause clears until reset
    assign hold_d = i_cond | (i_latching & latch_q & ~i_reset);
    assign act_d  = hold_d & ~(sil_q | (i_silenceable & i_silence));
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            latch_q   <= 1'b0;
            sil_q     <= 1'b0;
            cond_q    <= 1'b0;
            o_active  <= 1'b0;
            o_contact <= 1'b0;
        end else begin
            cond_q   <= i_cond;
            latch_q  <= hold_d;
            // rising cause starts a new occurrence, so it wins over silence
            if (i_cond & ~cond_q)
                sil_q <= 1'b0;
            else if (~hold_d)
                sil_q <= 1'b0;
            else if (i_silenceable & i_silence)
                sil_q <= 1'b1;
            o_active  <= act_d;
            // energized: closed when idle, open on alarm or fault (fail-safe)
            if (i_energized)
                o_contact <= ~(act_d | i_fault_any);
            else
                o_contact <= act_d;
        end
    end
endmodule // gar_level_out

// >>> pkg/gar_defs.vh
// gar_defs.vh: shared constants for the gas alarm relay logic
// assumes: included by bare name from the core files
`ifndef GAR_DEFS_VH
`define GAR_DEFS_VH
`define GAR_LVL_FIRST   0
`define GAR_LVL_SECOND  1
`define GAR_LVL_THIRD   2
`define GAR_LVL_FAULT   3
`define GAR_NUM_LVL     4
`define GAR_WIRED_MAX   4
`define GAR_PER_PAGE    8
`define GAR_PAGE_TMO_MS 30
`define GAR_CLK_MHZ     250
`define GAR_MS_DIV      250000
`endif
